// ==== design/btc_relay_ctrl.sv ====
/*
 * btc_relay_ctrl: breaker trip and close relay control with contact
 * input debouncing and an AHB-Lite register slave.
 * assumes initiating commands come from logic on core_clk and contact
 * inputs arrive asynchronously from pins.
 */
`timescale 1ns/1ps
// How it works
// - eight contact inputs, each debounced
// - accept after one pass plus debounce
// - inputs one, two are breaker aux
// - hold until confirmed and initiator reset
// - two second fallback without position change
// - no aux: bf delay or 100 ms
// - no aux: close held 200 ms
// - seal-in added to reset, default 40 ms
// - open aux assigned: trip until open
// - only closed aux: trip until open
// - closed aux assigned: close until closed
// - only open aux: close until closed
// - seal-in 0.00 to 9.99 s, 10 ms
// - block input stops trip relay energizing
module btc_relay_ctrl
    import btc_pkg::*;
#(
    parameter int PASS_CYC = PASS_CYCLES
) (
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic [7:0]  contact_in,
    input  wire logic        trip_init,
    input  wire logic        close_init,
    input  wire logic        bf_expired,
    output logic             trip_coil,
    output logic             close_coil,
    output logic [7:0]       contact_state
);
    // ****************************************
    // relay sequencer step
    // ****************************************
    function automatic btc_rly_s relay_step(
        input btc_rly_s    r,
        input logic        tick,
        input logic        init,
        input logic        blk,
        input logic        aux_any,
        input logic        confirm,
        input logic        alt_done,
        input logic [13:0] alt_lim,
        input logic        from_start,
        input logic [13:0] seal
    );
        btc_rly_s n;
        logic     done;
        n        = r;
        done     = 1'b0;
        n.init_q = init;
        unique case (r.st)
            RLY_OFF: begin
                if (init && !r.init_q && !blk) begin
                    n.st  = RLY_ON;
                    n.tmr = '0;
                end
            end
            RLY_ON: begin
                if (tick && (from_start || !init) && r.tmr != TMR_NEVER) begin
                    n.tmr = r.tmr + 14'h0001;
                end
                if (init && !from_start) begin
                    n.tmr = '0;
                end
                if (aux_any) begin
                    done = !init && (confirm || n.tmr >= FALLBACK_PASSES);
                end else begin
                    done = alt_done || ((from_start || !init) && n.tmr >= alt_lim);
                end
                if (blk) begin
                    n.st = RLY_OFF;
                end else if (done) begin
                    n.st  = (seal == 14'h0000) ? RLY_OFF : RLY_SEAL;
                    n.tmr = '0;
                end
            end
            RLY_SEAL: begin
                if (tick) begin
                    n.tmr = r.tmr + 14'h0001;
                end
                if (blk || n.tmr >= seal) begin
                    n.st = RLY_OFF;
                end else if (init && !r.init_q) begin
                    n.st  = RLY_ON;
                    n.tmr = '0;
                end
            end
            default: begin
                n.st = RLY_OFF;
            end
        endcase
        n.coil = (n.st != RLY_OFF);
        return n;
    endfunction

    btc_state_s  s;
    btc_state_s  next_s;
    logic        pass_tick;
    logic        aux_any;
    logic        trip_cfm;
    logic        close_cfm;
    logic [13:0] trip_seal_p;
    logic [13:0] close_seal_p;
    logic [6:0]  wv;
    logic [9:0]  sv;

    // pass time base and derived settings
    assign pass_tick    = (s.pre == 18'(PASS_CYC - 1));
    assign aux_any      = s.ctrl[CLOSED_ASG_BIT] | s.ctrl[OPEN_ASG_BIT];
    assign trip_cfm     = s.ctrl[OPEN_ASG_BIT] ? s.deb[1] : ~s.deb[0];
    assign close_cfm    = s.ctrl[CLOSED_ASG_BIT] ? s.deb[0] : ~s.deb[1];
    assign trip_seal_p  = 14'({4'h0, s.trip_seal} * SEAL_STEP_PASSES);
    assign close_seal_p = 14'({4'h0, s.close_seal} * SEAL_STEP_PASSES);

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        next_s     = s;
        wv         = '0;
        sv         = '0;
        next_s.pre = pass_tick ? 18'h0_0000 : s.pre + 18'h0_0001;
        // three stage pin synchroniser
        next_s.s1  = contact_in;
        next_s.s2  = s.s1;
        next_s.s3  = s.s2;
        for (int i = 0; i < 8; i++) begin
            if (s.s2[i] == s.s3[i]) begin
                next_s.pin[i] = s.s3[i];
            end
            if (s.pin[i] == s.deb[i]) begin
                next_s.dcnt[i] = '0;
            end else if (pass_tick) begin
                if (s.dcnt[i] >= s.deb_ms) begin
                    next_s.deb[i]  = s.pin[i];
                    next_s.dcnt[i] = '0;
                end else begin
                    next_s.dcnt[i] = s.dcnt[i] + 7'h01;
                end
            end
        end
        next_s.trip  = relay_step(s.trip, pass_tick, trip_init, s.ctrl[TRIP_BLK_BIT], aux_any,
                                  trip_cfm, s.ctrl[BF_EN_BIT] & bf_expired,
                                  s.ctrl[BF_EN_BIT] ? TMR_NEVER : NO_BF_PASSES, 1'b0, trip_seal_p);
        next_s.close = relay_step(s.close, pass_tick, close_init, 1'b0, aux_any,
                                  close_cfm, 1'b0, CLOSE_FIX_PASSES, ~aux_any, close_seal_p);
        // bus data phase: apply a pending write
        next_s.rdy     = 1'b1;
        next_s.resp    = 1'b0;
        next_s.wr_pend = 1'b0;
        if (s.wr_pend) begin
            unique case (s.wr_addr)
                CTRL_OFS: begin
                    next_s.ctrl = hwdata[3:0];
                end
                DEB_OFS: begin
                    wv = (hwdata[31:7] != '0) ? DEB_MAX : hwdata[6:0];
                    next_s.deb_ms = (wv < DEB_MIN) ? DEB_MIN : ((wv > DEB_MAX) ? DEB_MAX : wv);
                end
                SEAL_OFS: begin
                    sv = hwdata[TRIP_SEAL_LSB +: 10];
                    next_s.trip_seal = (sv > SEAL_MAX) ? SEAL_MAX : sv;
                    sv = hwdata[CLOSE_SEAL_LSB +: 10];
                    next_s.close_seal = (sv > SEAL_MAX) ? SEAL_MAX : sv;
                end
                default: begin
                end
            endcase
        end
        // bus address phase, read settings from updated values, status from current state
        if (hsel && htrans[1] && hready) begin
            if (hwrite) begin
                next_s.wr_pend = (hsize == HSIZE_WORD);
                next_s.wr_addr = haddr[7:0];
            end else begin
                next_s.hrdata = '0;
                unique case (haddr[7:0])
                    CTRL_OFS: next_s.hrdata[3:0] = next_s.ctrl;
                    DEB_OFS: next_s.hrdata[6:0] = next_s.deb_ms;
                    SEAL_OFS: begin
                        next_s.hrdata[TRIP_SEAL_LSB +: 10]  = next_s.trip_seal;
                        next_s.hrdata[CLOSE_SEAL_LSB +: 10] = next_s.close_seal;
                    end
                    STATUS_OFS: begin
                        next_s.hrdata[ST_DEB_LSB +: 8] = s.deb;
                        next_s.hrdata[ST_TRIP_BIT]     = s.trip.coil;
                        next_s.hrdata[ST_CLOSE_BIT]    = s.close.coil;
                        next_s.hrdata[ST_PIN_LSB +: 8] = s.pin;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // state register
    always_ff @(posedge core_clk) begin
        if (reset) begin
            s            <= '0;
            s.ctrl       <= CTRL_RST;
            s.deb_ms     <= DEB_RST;
            s.trip_seal  <= SEAL_RST;
            s.close_seal <= SEAL_RST;
            s.rdy        <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // outputs straight from the state register
    assign hreadyout     = s.rdy;
    assign hresp         = s.resp;
    assign hrdata        = s.hrdata;
    assign trip_coil     = s.trip.coil;
    assign close_coil    = s.close.coil;
    assign contact_state = s.deb;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    chk_deb_restart: assert property (s.pin[0] == s.deb[0] |=> s.dcnt[0] == 7'h00)
        else $error("debounce count not restarted");
    chk_deb_on_pass: assert property (s.deb != $past(s.deb) |-> $past(pass_tick))
        else $error("debounced level changed off a pass");
    chk_timer_pass: assert property (s.trip.st == RLY_SEAL && $past(s.trip.st) == RLY_SEAL
        && s.trip.tmr != $past(s.trip.tmr) |-> $past(pass_tick))
        else $error("seal timer moved off a pass");
    chk_dcnt_pass: assert property (s.dcnt[0] > $past(s.dcnt[0]) |-> $past(pass_tick))
        else $error("debounce count moved off a pass");
    chk_pin_agree: assert property (s.pin[0] != $past(s.pin[0]) |-> $past(s.s2[0]) == $past(s.s3[0]))
        else $error("pin level taken before stages agreed");
    chk_trip_block: assert property (s.ctrl[TRIP_BLK_BIT] |=> !trip_coil)
        else $error("trip energized while blocked");
    chk_trip_hold: assert property (aux_any && trip_coil && trip_init
        && !s.ctrl[TRIP_BLK_BIT] |=> trip_coil)
        else $error("trip dropped while initiator active");
    chk_trip_open: assert property (s.trip.st == RLY_ON && s.ctrl[OPEN_ASG_BIT] && !s.deb[1]
        && !s.ctrl[TRIP_BLK_BIT] && s.trip.tmr < FALLBACK_PASSES - 14'h0001 |=> trip_coil)
        else $error("trip released before breaker open");
    chk_close_hold: assert property (s.close.st == RLY_ON && s.ctrl[CLOSED_ASG_BIT] && !s.deb[0]
        && s.close.tmr < FALLBACK_PASSES - 14'h0001 |=> close_coil)
        else $error("close released before breaker closed");
    // one contact assigned: hold until it reports
    chk_trip_closed: assert property (s.trip.st == RLY_ON && s.ctrl[CLOSED_ASG_BIT]
        && !s.ctrl[OPEN_ASG_BIT] && s.deb[0] && !s.ctrl[TRIP_BLK_BIT]
        && s.trip.tmr < FALLBACK_PASSES - 14'h0001 |=> trip_coil)
        else $error("trip released before closed contact dropped");
    chk_close_open: assert property (s.close.st == RLY_ON && s.ctrl[OPEN_ASG_BIT]
        && !s.ctrl[CLOSED_ASG_BIT] && s.deb[1]
        && s.close.tmr < FALLBACK_PASSES - 14'h0001 |=> close_coil)
        else $error("close released before open contact dropped");
    chk_fallback_end: assert property (s.trip.st == RLY_ON && aux_any && !trip_init
        && s.trip.tmr >= FALLBACK_PASSES && !s.ctrl[TRIP_BLK_BIT] |=> s.trip.st != RLY_ON)
        else $error("trip not released at fallback");
    chk_trip_nobf: assert property (s.trip.st == RLY_ON && !aux_any && !s.ctrl[BF_EN_BIT]
        && !trip_init && s.trip.tmr >= NO_BF_PASSES |=> s.trip.st != RLY_ON)
        else $error("trip not released after 100 ms");
    chk_close_fix: assert property (s.close.st == RLY_ON && !aux_any
        && s.close.tmr >= CLOSE_FIX_PASSES |=> s.close.st != RLY_ON)
        else $error("close not released after 200 ms");
    chk_seal_hold: assert property (s.trip.st == RLY_SEAL && !s.ctrl[TRIP_BLK_BIT]
        && s.trip.tmr < trip_seal_p - 14'h0001 |=> trip_coil)
        else $error("seal-in ended early");

    // main scenarios reached
    cov_trip_seal: cover property (s.trip.st == RLY_ON ##1 s.trip.st == RLY_SEAL);
    cov_close_cfm: cover property (s.close.st == RLY_ON && close_cfm && !close_init);
    cov_deb_accept: cover property ($rose(s.deb[0]));
    cov_fallback: cover property (s.trip.st == RLY_ON && s.trip.tmr == FALLBACK_PASSES);
    cov_nobf_end: cover property (s.trip.st == RLY_ON && !aux_any && s.trip.tmr == NO_BF_PASSES);
endmodule // btc_relay_ctrl

// ==== shared/btc_pkg.sv ====
/*
 * btc_pkg: constants, state types and register map of the breaker
 * trip/close relay controller.
 * assumes a 200 MHz core clock and a 1 ms protection pass.
 */
package btc_pkg;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 5;
    localparam int PASS_NS       = 1_000_000;             // one protection pass
    localparam int PASS_CYCLES   = PASS_NS / CLK_PERIOD_NS;
    localparam int PASS_MS       = 1;
    localparam int FALLBACK_MS   = 2000;                  // no position change
    localparam int NO_BF_MS      = 100;                   // trip, no aux, no bf
    localparam int CLOSE_FIX_MS  = 200;                   // close, no aux
    localparam int SEAL_STEP_MS  = 10;
    localparam logic [13:0] FALLBACK_PASSES  = 14'(FALLBACK_MS / PASS_MS);
    localparam logic [13:0] NO_BF_PASSES     = 14'(NO_BF_MS / PASS_MS);
    localparam logic [13:0] CLOSE_FIX_PASSES = 14'(CLOSE_FIX_MS / PASS_MS);
    localparam logic [13:0] SEAL_STEP_PASSES = 14'(SEAL_STEP_MS / PASS_MS);
    localparam logic [13:0] TMR_NEVER        = 14'h3FFF;

    // ****************************************
    // register map and fields
    // ****************************************
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] DEB_OFS    = 8'h04;
    localparam logic [7:0] SEAL_OFS   = 8'h08;
    localparam logic [7:0] STATUS_OFS = 8'h0C;
    localparam int TRIP_BLK_BIT   = 0;
    localparam int BF_EN_BIT      = 1;
    localparam int CLOSED_ASG_BIT = 2;
    localparam int OPEN_ASG_BIT   = 3;
    localparam int TRIP_SEAL_LSB  = 0;
    localparam int CLOSE_SEAL_LSB = 16;
    localparam int ST_DEB_LSB     = 0;
    localparam int ST_TRIP_BIT    = 8;
    localparam int ST_CLOSE_BIT   = 9;
    localparam int ST_PIN_LSB     = 16;
    localparam logic [3:0] CTRL_RST = 4'b1100;           // both aux assigned
    localparam logic [6:0] DEB_RST  = 7'h02;
    localparam logic [6:0] DEB_MIN  = 7'h01;
    localparam logic [6:0] DEB_MAX  = 7'h40;
    localparam logic [9:0] SEAL_RST = 10'h004;           // 40 ms
    localparam logic [9:0] SEAL_MAX = 10'h3E7;           // 9.99 s
    localparam logic [2:0] HSIZE_WORD = 3'b010;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {
        RLY_OFF  = 2'b00,
        RLY_ON   = 2'b01,
        RLY_SEAL = 2'b10
    } btc_rly_e;

    typedef struct packed {
        btc_rly_e    st;
        logic [13:0] tmr;
        logic        init_q;
        logic        coil;
    } btc_rly_s;

    typedef struct packed {
        logic [17:0]     pre;
        logic [7:0]      s1;
        logic [7:0]      s2;
        logic [7:0]      s3;
        logic [7:0]      pin;
        logic [7:0]      deb;
        logic [7:0][6:0] dcnt;
        logic [3:0]      ctrl;
        logic [6:0]      deb_ms;
        logic [9:0]      trip_seal;
        logic [9:0]      close_seal;
        btc_rly_s        trip;
        btc_rly_s        close;
        logic            wr_pend;
        logic [7:0]      wr_addr;
        logic [31:0]     hrdata;
        logic            rdy;
        logic            resp;
    } btc_state_s;
endpackage

// ==== verif/btc_breaker_model.sv ====
/*
 * btc_breaker_model: circuit breaker with trip and close coils and
 * two auxiliary contacts.
 * assumes coils are sampled on core_clk and the breaker starts closed.
 */
`timescale 1ns/1ps
module btc_breaker_model #(
    parameter int RESP_CYC = 200
) (
    input  wire logic core_clk,
    input  wire logic trip_coil,
    input  wire logic close_coil,
    input  wire logic stuck,
    output logic      closed_aux,
    output logic      open_aux
);
    // ****************************************
    // mechanism
    // ****************************************
    logic closed = 1'b1;
    int   on_cyc = 0;

    // moves once a coil has been energized long enough, unless jammed
    always @(posedge core_clk) begin
        on_cyc <= (trip_coil | close_coil) ? on_cyc + 1 : 0;
        if (!stuck && on_cyc == RESP_CYC) begin
            closed <= close_coil;
        end
    end

    assign closed_aux = closed;
    assign open_aux   = ~closed;
endmodule // btc_breaker_model

// ==== verif/tb_btc_relay_ctrl.sv ====
/*
 * tb_btc_relay_ctrl: self-checking bench for the trip/close relay block.
 * assumes the breaker model sits on contact inputs one and two.
 */
`timescale 1ns/1ps
module tb_btc_relay_ctrl
    import btc_pkg::*;
;
    // ****************************************
    // signals
    // ****************************************
    localparam int P = 20;                  // cycles per pass in sim
    localparam logic [7:0]  WA [7] = '{8'h1C, CTRL_OFS, DEB_OFS, DEB_OFS, DEB_OFS, SEAL_OFS, SEAL_OFS};
    localparam logic [31:0] WD [7] = '{32'hFFFF_FFFF, 32'h0000_0001, 32'h0000_0000, 32'h0000_0064,
                                       32'h0000_0002, 32'h03E8_03E8, 32'h0004_0004};
    localparam logic [31:0] WE [7] = '{32'h0000_0000, 32'h0000_000C, 32'h0000_0001, 32'h0000_0040,
                                       32'h0000_0002, 32'h03E7_03E7, 32'h0004_0004};
    localparam logic [3:0]  ASG [3] = '{4'hC, 4'h4, 4'h8};
    logic        core_clk   = 1'b0;
    logic        reset      = 1'b1;
    logic        hsel       = 1'b0;
    logic        hwrite     = 1'b0;
    logic [1:0]  htrans     = 2'b00;
    logic [2:0]  hsize      = HSIZE_WORD;
    logic [31:0] haddr      = 32'h0000_0000;
    logic [31:0] hwdata     = 32'h0000_0000;
    logic        trip_init  = 1'b0;
    logic        close_init = 1'b0;
    logic        bf_expired = 1'b0;
    logic        stuck      = 1'b0;
    logic [5:0]  aux_hi     = 6'h00;
    logic        hready, hresp, trip_coil, close_coil, closed_aux, open_aux;
    logic [31:0] hrdata, rnd, st;
    logic [7:0]  contact_state;
    logic [1:0]  coil_q     = 2'b00;
    logic [1:0]  coils;
    logic        rd_ph      = 1'b0;
    int          cyc        = 0;
    int          mismatches = 0;
    int          samples_checked = 0;
    int          t0 [2];
    int          dur_q [2][$];
    logic [31:0] rd_q [$];

    always #2.5 core_clk = ~core_clk;

    // both coils as one vector for the monitor
    assign coils = {close_coil, trip_coil};

    btc_relay_ctrl #(.PASS_CYC(P)) btc_relay_ctrl_inst (
        .core_clk(core_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
        .hresp(hresp), .hrdata(hrdata), .contact_in({aux_hi, open_aux, closed_aux}),
        .trip_init(trip_init), .close_init(close_init), .bf_expired(bf_expired),
        .trip_coil(trip_coil), .close_coil(close_coil), .contact_state(contact_state));

    btc_breaker_model #(.RESP_CYC(10 * P)) btc_breaker_model_inst (
        .core_clk(core_clk), .trip_coil(trip_coil), .close_coil(close_coil), .stuck(stuck),
        .closed_aux(closed_aux), .open_aux(open_aux));

    // ****************************************
    // tasks
    // ****************************************
    task automatic compare(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // coil held time against expected passes, two passes of slack each way
    task automatic check_dur(input int i, input int got);
        int e;
        e = (dur_q[i].size() > 0) ? dur_q[i].pop_front() : -1000;
        samples_checked++;
        if (got < (e - 2) * P || got > (e + 2) * P) begin
            mismatches++;
            $display("mismatch at %0t: coil %0d held %0d cycles, expected %0d passes", $time, i, got, e);
        end
    endtask

    task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [2:0] s);
        @(posedge core_clk);
        hsel   <= 1'b1;
        haddr  <= {24'h00_0000, a};
        htrans <= 2'b10;
        hwrite <= w;
        hsize  <= s;
        do @(posedge core_clk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge core_clk); while (hready !== 1'b1);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        ahb(a, 1'b0, 32'h0000_0000, HSIZE_WORD);
    endtask

    // raise one initiator, drop it after hold passes, wait for release
    task automatic pulse(input int which, input int hold, input int bf_at, input int exp);
        if (exp >= 0) dur_q[which].push_back(exp);
        @(posedge core_clk);
        if (which == 0) trip_init <= 1'b1; else close_init <= 1'b1;
        repeat (hold * P) @(posedge core_clk);
        trip_init  <= 1'b0;
        close_init <= 1'b0;
        if (bf_at > 0) begin
            repeat ((bf_at - hold) * P) @(posedge core_clk);
            bf_expired <= 1'b1;
        end
        for (int n = 0; n < 3000 * P && (trip_coil | close_coil) !== 1'b0; n++) @(posedge core_clk);
        if ((trip_coil | close_coil) !== 1'b0) begin
            compare({31'h0000_0000, trip_coil | close_coil}, 32'h0000_0000);
        end
        bf_expired <= 1'b0;
        repeat (4 * P) @(posedge core_clk);
    endtask

    task automatic summarize();
        $display("checked %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ****************************************
    // monitor
    // ****************************************
    // read data phase follows a taken read address phase
    always @(posedge core_clk) begin
        rd_ph <= hsel & htrans[1] & ~hwrite & hready;
        cyc   <= cyc + 1;
    end

    // compare read data and coil pulse lengths against notes
    always @(negedge core_clk) begin
        if (rd_ph) begin
            compare(hrdata, rd_q.pop_front());
            compare({31'h0000_0000, hresp}, 32'h0000_0000);
            compare({31'h0000_0000, hready}, 32'h0000_0001);
        end
        for (int i = 0; i < 2; i++) begin
            if (coils[i] === 1'b1 && coil_q[i] !== 1'b1) t0[i] = cyc;
            if (coils[i] === 1'b0 && coil_q[i] === 1'b1) check_dur(i, cyc - t0[i]);
        end
        coil_q = coils;
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        rnd = $urandom(96);
        rnd = $urandom();
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        rd(CTRL_OFS, 32'h0000_000C);
        rd(SEAL_OFS, 32'h0004_0004);
        for (int i = 0; i < 7; i++) begin
            ahb(WA[i], 1'b1, WD[i], (i == 1) ? 3'b000 : HSIZE_WORD);
            rd(WA[i], WE[i]);
        end
        aux_hi <= rnd[5:0];
        repeat (6 * P) @(posedge core_clk);
        st = {8'h00, rnd[5:0], 2'b01, 8'h00, rnd[5:0], 2'b01};
        rd(STATUS_OFS, st);
        compare({24'h00_0000, contact_state}, {24'h00_0000, st[7:0]});
        aux_hi <= ~rnd[5:0];
        repeat (2 * P - 4) @(posedge core_clk);
        aux_hi <= rnd[5:0];
        repeat (6 * P) @(posedge core_clk);
        rd(STATUS_OFS, st);
        for (int i = 0; i < 3; i++) begin
            ahb(CTRL_OFS, 1'b1, {28'h000_0000, ASG[i]}, HSIZE_WORD);
            pulse(0, 2, 0, 53);
            pulse(1, 2, 0, 53);
        end
        ahb(SEAL_OFS, 1'b1, 32'h0003_0000, HSIZE_WORD);
        ahb(CTRL_OFS, 1'b1, 32'h0000_0002, HSIZE_WORD);
        pulse(0, 2, 30, 30);
        ahb(CTRL_OFS, 1'b1, 32'h0000_0000, HSIZE_WORD);
        pulse(0, 5, 0, 105);
        pulse(1, 5, 0, 230);
        ahb(CTRL_OFS, 1'b1, 32'h0000_000D, HSIZE_WORD);
        pulse(0, 3, 0, -1);
        stuck <= 1'b1;
        ahb(SEAL_OFS, 1'b1, 32'h0000_0000, HSIZE_WORD);
        ahb(CTRL_OFS, 1'b1, 32'h0000_000C, HSIZE_WORD);
        pulse(0, 2, 0, 2002);
        compare(32'(dur_q[0].size() + dur_q[1].size()), 32'h0000_0000);
        summarize();
    end

    // watchdog against a hung handshake or coil
    initial begin
        #400_000;
        mismatches++;
        summarize();
    end
endmodule // tb_btc_relay_ctrl
